// ==== core/supply_supervisor_watchdog_map.svh ====
// timing constants and rule summary for the supply supervisor watchdog
// Functional notes
// - active-low reset always present; optional active-high output is its exact complement
// - push-pull output normally; open-drain variant only pulls low, else releases
// - any strobe edge retriggers the watchdog; processor must toggle it periodically
// - missing strobe edge within timeout gives one reset-delay long reset pulse
// - a timeout restarts the watchdog timer from zero
// - floating strobe input makes internal retriggers, so watchdog never resets
// - standard variant latches reset low if strobe toggles during reset
// - latch-free variant releases reset normally despite strobe edges during reset
// - reset released only after supply-ok shows rise above upper threshold
// - reset asserted whenever supply falls below the lower threshold
// - default reset delay period is 200 ms
// - short-delay variant uses a 25 ms reset delay
// - reset high only with manual reset high and supply ok; else low
// - low manual reset forces reset regardless of supply or watchdog
`ifndef SUPPLY_SUPERVISOR_WATCHDOG_MAP_SVH
`define SUPPLY_SUPERVISOR_WATCHDOG_MAP_SVH
`define SSW_CLK_HZ          40000000
`define SSW_DELAY_LONG_MS   200
`define SSW_DELAY_SHORT_MS  25
`define SSW_TOUT_LONG_MS    1600
`define SSW_TOUT_SHORT_MS   200
`define SSW_MS_CYCLES(ms)   ((ms) * (`SSW_CLK_HZ / 1000))
`define SSW_TICK_DIV        40
`endif

// ==== core/supply_supervisor_watchdog_pkg.sv ====
// types for the supply supervisor watchdog
package supply_supervisor_watchdog_pkg;
   typedef enum logic [1:0] {
      st_hold,
      st_delay,
      st_run,
      st_latched
   } sup_state_t;
endpackage : supply_supervisor_watchdog_pkg

// ==== core/supply_supervisor_timebase.sv ====
// free-running tick generator for the supervisor counters
`timescale 1ns/1ps
`default_nettype none
module supply_supervisor_timebase #(
   parameter int unsigned DIV = 40
) (
   input  wire logic clk,      // system clock
   input  wire logic rst_n,    // synchronised reset
   output var  logic tick      // one-cycle pulse every DIV clocks
);
   localparam int W = $clog2(DIV + 1);
   logic [W-1:0] cnt_reg;
   wire          wrap = (cnt_reg == W'(DIV - 1));

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_reg <= '0;
         tick    <= 1'b0;
      end else begin
         cnt_reg <= wrap ? '0 : cnt_reg + W'(1);
         tick    <= wrap;
      end
   end
endmodule : supply_supervisor_timebase
`default_nettype wire

// ==== core/supply_supervisor_watchdog.sv ====
// supply supervisor with watchdog and reset pulse generation
`timescale 1ns/1ps
`default_nettype none
`include "supply_supervisor_watchdog_map.svh"
module supply_supervisor_watchdog
   import supply_supervisor_watchdog_pkg::*;
#(
   parameter bit          SHORT_DELAY = 1'b0,  // 25 ms delay variant
   parameter bit          LATCH_FREE  = 1'b0,  // no latch on strobe in reset
   parameter bit          OPEN_DRAIN  = 1'b0,  // open-drain reset stage
   parameter bit          HAS_WATCHDOG = 1'b1, // watchdog fitted
   parameter int unsigned TICK_DIV    = `SSW_TICK_DIV,
   parameter int unsigned DELAY_TICKS =
      `SSW_MS_CYCLES(SHORT_DELAY ? `SSW_DELAY_SHORT_MS : `SSW_DELAY_LONG_MS)
      / `SSW_TICK_DIV,
   parameter int unsigned TOUT_TICKS  =
      `SSW_MS_CYCLES(SHORT_DELAY ? `SSW_TOUT_SHORT_MS : `SSW_TOUT_LONG_MS)
      / `SSW_TICK_DIV
) (
   input  wire logic clk,                  // 40 MHz clock
   input  wire logic reset_n,              // async reset, active low
   input  wire logic supply_ok,            // supply above threshold, hyst.
   input  wire logic manual_reset_n,       // manual reset, active low
   input  wire logic watchdog_strobe_in,   // strobe level
   input  wire logic watchdog_strobe_hiz,  // strobe pin seen floating
   output var  logic sys_reset_n,          // push-pull active-low reset
   output var  logic sys_reset,            // active-high complement
   output var  logic sys_reset_out,        // open-drain pin: output value
   output var  logic sys_reset_oe          // open-drain pin: enable
);
   localparam int CW = $clog2(TOUT_TICKS > DELAY_TICKS ?
                              TOUT_TICKS + 1 : DELAY_TICKS + 1);

   // ************************************************************
   // reset release
   // ************************************************************
   logic rst_meta_reg;
   logic rst_n_reg;
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rst_meta_reg <= 1'b0;
         rst_n_reg    <= 1'b0;
      end else begin
         rst_meta_reg <= 1'b1;
         rst_n_reg    <= rst_meta_reg;
      end
   end

   // ************************************************************
   // time base
   // ************************************************************
   logic tick;
   supply_supervisor_timebase #(
      .DIV   (TICK_DIV)
   ) u_timebase (
      .clk   (clk),
      .rst_n (rst_n_reg),
      .tick  (tick)
   );

   // ************************************************************
   // strobe edge detection
   // ************************************************************
   logic strobe_prev_reg;
   logic strobe_seen_reg;
   logic hiz_pulse_reg;
   // strobe_seen_reg masks the first compare after reset, so a strobe
   // resting high does not look like an edge and latch the reset
   always_ff @(posedge clk or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         strobe_prev_reg <= 1'b0;
         strobe_seen_reg <= 1'b0;
         hiz_pulse_reg   <= 1'b0;
      end else begin
         strobe_prev_reg <= watchdog_strobe_in;
         strobe_seen_reg <= 1'b1;
         hiz_pulse_reg   <= watchdog_strobe_hiz & tick;
      end
   end
   wire strobe_edge = strobe_seen_reg
                    & (watchdog_strobe_in ^ strobe_prev_reg);
   wire retrigger   = (strobe_edge & ~watchdog_strobe_hiz)
                    | hiz_pulse_reg | watchdog_strobe_hiz;

   // ************************************************************
   // supervisor state machine
   // ************************************************************
   sup_state_t    state_reg, state_next;
   logic [CW-1:0] cnt_reg, cnt_next;
   logic          strobe_in_reset_reg, strobe_in_reset_next;

   wire hold_cond  = ~manual_reset_n | ~supply_ok;
   wire delay_done = tick & (cnt_reg >= CW'(DELAY_TICKS - 1));
   wire tout_hit   = HAS_WATCHDOG & tick & ~retrigger
                     & (cnt_reg >= CW'(TOUT_TICKS - 1));
   wire latch_on   = ~LATCH_FREE & HAS_WATCHDOG;

   always_comb begin
      state_next           = state_reg;
      cnt_next             = cnt_reg;
      strobe_in_reset_next = strobe_in_reset_reg;
      case (state_reg)
         st_hold: begin
            cnt_next = '0;
            if (strobe_edge & latch_on)
               strobe_in_reset_next = 1'b1;
            if (!hold_cond) begin
               if (strobe_in_reset_reg | (strobe_edge & latch_on))
                  state_next = st_latched;
               else
                  state_next = st_delay;
            end
         end
         st_delay: begin
            if (hold_cond) begin
               state_next = st_hold;
               cnt_next   = '0;
            end else if (strobe_edge & latch_on) begin
               state_next = st_latched;
            end else if (delay_done) begin
               state_next = st_run;
               cnt_next   = '0;
            end else if (tick) begin
               cnt_next = cnt_reg + CW'(1);
            end
         end
         st_run: begin
            if (hold_cond) begin
               state_next           = st_hold;
               cnt_next             = '0;
               strobe_in_reset_next = 1'b0;
            end else if (tout_hit) begin
               state_next = st_delay;
               cnt_next   = '0;
            end else if (retrigger) begin
               cnt_next = '0;
            end else if (tick) begin
               cnt_next = cnt_reg + CW'(1);
            end
         end
         st_latched: begin
            cnt_next = '0;
         end
         default: begin
            state_next = st_hold;
            cnt_next   = '0;
         end
      endcase
   end

   wire assert_next = (state_next != st_run) | hold_cond;

   always_ff @(posedge clk or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         state_reg           <= st_hold;
         cnt_reg             <= '0;
         strobe_in_reset_reg <= 1'b0;
      end else begin
         state_reg           <= state_next;
         cnt_reg             <= cnt_next;
         strobe_in_reset_reg <= strobe_in_reset_next;
      end
   end

   // ************************************************************
   // output stage
   // ************************************************************
   always_ff @(posedge clk or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         sys_reset_n   <= 1'b0;
         sys_reset     <= 1'b1;
         sys_reset_out <= 1'b0;
         sys_reset_oe  <= 1'b1;
      end else begin
         sys_reset_n   <= ~assert_next;
         sys_reset     <= assert_next;
         sys_reset_out <= OPEN_DRAIN ? 1'b0 : ~assert_next;
         sys_reset_oe  <= OPEN_DRAIN ? assert_next : 1'b1;
      end
   end
endmodule : supply_supervisor_watchdog
`default_nettype wire

// ==== sim/supply_supervisor_watchdog_properties.sv ====
// port assertions for the supply supervisor
`timescale 1ns/1ps
`default_nettype none
module supply_supervisor_watchdog_properties #(
   parameter int unsigned TICK_DIV = 2, DELAY_TICKS = 10, TOUT_TICKS = 20
) (
   input wire logic clk, reset_n, supply_ok, manual_reset_n,
   input wire logic watchdog_strobe_in, watchdog_strobe_hiz,
   input wire logic sys_reset_n, sys_reset, sys_reset_out, sys_reset_oe
);
   localparam int DLO = (DELAY_TICKS - 1) * TICK_DIV;
   localparam int TLO = (TOUT_TICKS - 1) * TICK_DIV;
   localparam int THI = (TOUT_TICKS + 1) * TICK_DIV + 6;
   logic strobe_q, vld, lat;
   int   idle, low;
   wire logic edge_seen = vld && (watchdog_strobe_in != strobe_q);
   wire logic clr = edge_seen || watchdog_strobe_hiz || !sys_reset_n;
   // idle counts cycles without retrigger, low counts reset cycles
   always_ff @(posedge clk or negedge reset_n)
      if (!reset_n) {strobe_q, vld, lat, idle, low} <= '0;
      else begin
         strobe_q <= watchdog_strobe_in;
         vld <= 1'b1;
         lat <= lat || (edge_seen && !sys_reset_n);
         idle <= clr ? 0 : idle + 1;
         low <= sys_reset_n ? 0 : low + 1;
      end
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   AST_COMPL: assert property (sys_reset == !sys_reset_n)
      else $error("bad complement");
   AST_PUSH: assert property (
      sys_reset_oe && sys_reset_out == sys_reset_n) else $error("bad pin");
   AST_SUPPLY: assert property (!supply_ok |=> !sys_reset_n)
      else $error("low supply ignored");
   AST_MANUAL: assert property (!manual_reset_n |=> !sys_reset_n)
      else $error("manual reset ignored");
   AST_RISE: assert property (
      $rose(sys_reset_n) |-> $past(supply_ok && manual_reset_n))
      else $error("release while held");
   AST_DELAY: assert property ($rose(sys_reset_n) |-> low >= DLO)
      else $error("reset too short");
   AST_TOUT: assert property (idle <= THI)
      else $error("timeout missed");
   AST_EARLY: assert property (
      $fell(sys_reset_n) && $past(supply_ok && manual_reset_n) |-> idle >= TLO)
      else $error("timeout too early");
   AST_LATCH: assert property (lat && !sys_reset_n |=> !sys_reset_n)
      else $error("latch lost");
   cover property ($rose(sys_reset_n));
   cover property ($fell(sys_reset_n) && supply_ok && manual_reset_n);
   cover property (lat && !sys_reset_n);
endmodule : supply_supervisor_watchdog_properties
`default_nettype wire

// ==== sim/strobe_host_model.sv ====
// processor model toggling the watchdog strobe
`timescale 1ns/1ps
`default_nettype none
module strobe_host_model #(
   parameter int unsigned PERIOD = 8  // cycles between edges
) (
   input  wire logic clk,        // system clock
   input  wire logic run_rst_n,  // reset from the supervisor
   input  wire logic en,         // firmware alive
   input  wire logic wild,       // strobe even while in reset
   output var  logic strobe      // watchdog strobe
);
   int cnt = 0;
   initial strobe = 1'b0;
   always @(posedge clk)
      if ((en && run_rst_n) || wild) begin
         cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
         if (cnt == PERIOD - 1) strobe <= ~strobe;
      end
endmodule : strobe_host_model
`default_nettype wire

// ==== sim/supply_supervisor_watchdog_tb.sv ====
// self-checking bench for the supply supervisor
`timescale 1ns/1ps
`default_nettype none
module supply_supervisor_watchdog_tb;
   localparam int DIV = 2, DLY = 10, TOUT = 20;
   localparam int DLO = (DLY - 1) * DIV, DHI = (DLY + 1) * DIV + 4;
   localparam int TLO = (TOUT - 1) * DIV, THI = (TOUT + 1) * DIV + 6;
   logic clk = 0, reset_n = 0, supply_ok = 0, mr_n = 1;
   logic hiz = 0, en = 0, wild = 0;
   wire logic strobe, srn, sr, so, soe;
   int n_fail = 0, n_tests = 0, cyc = 0, n;
   initial forever #12.5 clk = ~clk;
   supply_supervisor_watchdog #(.TICK_DIV(DIV), .DELAY_TICKS(DLY),
      .TOUT_TICKS(TOUT)) u_dut (.clk(clk), .reset_n(reset_n),
      .supply_ok(supply_ok), .manual_reset_n(mr_n),
      .watchdog_strobe_in(strobe), .watchdog_strobe_hiz(hiz),
      .sys_reset_n(srn), .sys_reset(sr), .sys_reset_out(so),
      .sys_reset_oe(soe));
   strobe_host_model u_host (.clk(clk), .run_rst_n(srn), .en(en),
      .wild(wild), .strobe(strobe));
   task automatic check(string what, logic seen, logic exp);
      n_tests++;
      if (seen !== exp) begin
         n_fail++;
         $display("FAIL %s expected %b seen %b", what, exp, seen);
      end
   endtask : check
   task automatic tick(int k);
      repeat (k) @(negedge clk);
   endtask : tick
   task automatic wait_rst(logic v, int lim);
      n = 0;
      while (srn !== v && n < lim) begin
         tick(1);
         n++;
      end
   endtask : wait_rst
   function automatic logic in_rng(int lo, int hi);
      return n >= lo && n <= hi;
   endfunction : in_rng
   task automatic t_power;
      @(posedge clk) supply_ok <= 1'b1;
      wait_rst(1'b1, 200);
      check("delay", in_rng(DLO, DHI), 1'b1);
      check("high out", sr, 1'b0);
      check("pin value", so, 1'b1);
      check("pin enable", soe, 1'b1);
      @(posedge clk) en <= 1'b1;
      tick(4 * THI);
      check("alive", srn, 1'b1);
      $display("power done");
   endtask : t_power
   task automatic t_table;
      @(posedge clk) en <= 1'b0;
      tick(10);
      for (int i = 0; i < 3; i++) begin
         @(posedge clk) {mr_n, supply_ok} <= 2'(i);
         tick(DHI + 4);
         check("held", srn, 1'b0);
         check("high out", sr, 1'b1);
         check("pin low", so, 1'b0);
      end
      @(posedge clk) supply_ok <= 1'b1;
      wait_rst(1'b1, 200);
      check("release", in_rng(DLO, DHI), 1'b1);
      $display("table done");
   endtask : t_table
   task automatic t_timeout;
      wait_rst(1'b0, THI + 10);
      check("timeout", in_rng(TLO, THI), 1'b1);
      wait_rst(1'b1, DHI + 4);
      check("pulse", in_rng(DLO, DHI), 1'b1);
      wait_rst(1'b0, THI + 10);
      check("restart", in_rng(TLO, THI), 1'b1);
      wait_rst(1'b1, DHI + 4);
      @(posedge clk) hiz <= 1'b1;
      tick(3 * THI);
      check("floating", srn, 1'b1);
      @(posedge clk) hiz <= 1'b0;
      $display("timeout done");
   endtask : t_timeout
   task automatic t_latch;
      @(posedge clk) supply_ok <= 1'b0;
      tick(4);
      @(posedge clk) wild <= 1'b1;
      tick(40);
      @(posedge clk) wild <= 1'b0;
      @(posedge clk) supply_ok <= 1'b1;
      tick(2 * DHI);
      check("latched", srn, 1'b0);
      @(posedge clk) reset_n <= 1'b0;
      tick(3);
      @(posedge clk) reset_n <= 1'b1;
      wait_rst(1'b1, DHI + 8);
      check("recover", in_rng(DLO, DHI + 4), 1'b1);
      $display("latch done");
   endtask : t_latch
   task automatic finish_test;
      $display("tests %0d failures %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : finish_test
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         n_fail++;
         finish_test;
      end
   end
   initial begin
      tick(16);
      @(posedge clk) reset_n <= 1'b1;
      tick(4);
      t_power;
      t_table;
      t_timeout;
      t_latch;
      finish_test;
   end
endmodule : supply_supervisor_watchdog_tb
bind supply_supervisor_watchdog supply_supervisor_watchdog_properties #(
   .TICK_DIV(TICK_DIV), .DELAY_TICKS(DELAY_TICKS), .TOUT_TICKS(TOUT_TICKS)
) u_props (.*);
`default_nettype wire
